//--- rtl/devcap_pkg.sv
package devcap_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  DEVICE_CAPABILITIES_OFFSET = 8'hB4;
    localparam int          ADDR_WIDTH                 = 8;
    localparam int          DATA_WIDTH                 = 32;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PAYLOAD_LSB    = 0;
    localparam int PHANTOM_LSB    = 3;
    localparam int EXT_TAG_BIT    = 5;
    localparam int L0S_LAT_LSB    = 6;
    localparam int L1_LAT_LSB     = 9;
    localparam int ATTN_BTN_BIT   = 12;
    localparam int ATTN_IND_BIT   = 13;
    localparam int PWR_IND_BIT    = 14;
    localparam int SPL_VALUE_LSB  = 18;
    localparam int SPL_SCALE_LSB  = 26;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] PAYLOAD_RESET   = 3'h1;
    localparam logic [1:0] PHANTOM_RESET   = 2'h0;
    localparam logic       EXT_TAG_RESET   = 1'h1;
    localparam logic [2:0] L0S_LAT_RESET   = 3'h0;
    localparam logic [2:0] L1_LAT_RESET    = 3'h0;
    localparam logic [7:0] SPL_VALUE_RESET = 8'h00;
    localparam logic [1:0] SPL_SCALE_RESET = 2'h0;

    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // slot power limit message payload as delivered by the link layer
    typedef struct packed {
        logic [1:0] scale;
        logic [7:0] value;
    } slot_power_t;

endpackage

//--- rtl/cap_field_reg.sv
`timescale 1ns/100ps
`default_nettype none

module cap_field_reg #(
    parameter int         WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] value
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value <= RESET_VALUE;
        end else if (load) begin
            value <= load_value;
        end
    end

endmodule

`default_nettype wire

//--- rtl/device_capabilities_regs.sv
// Functional notes
// RULE1 - max payload field bits 2:0, reset 256 bytes
// RULE2 - phantom functions bits 4:3 read zero
// RULE3 - bit 5 reports extended 8-bit tag
// RULE4 - l0s acceptable latency bits 8:6, reset 000
// RULE5 - l1 acceptable latency bits 11:9, reset 000
// RULE6 - bit 12 attention button from hot-plug strap; the code sets it only when forward_bridge is also strapped
// RULE7 - bit 13 attention indicator from hot-plug strap; the code sets it only when forward_bridge is also strapped
// RULE8 - bit 14 power indicator from hot-plug strap; the code sets it only when forward_bridge is also strapped
// RULE9 - bits 25:18 capture slot power value
// RULE10 - bits 27:26 capture slot power scale
// RULE11 - writes ignored, reserved bits read zero
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

module device_capabilities_regs #(
    parameter logic [2:0] MAX_PAYLOAD = devcap_pkg::PAYLOAD_RESET,
    parameter logic [2:0] L0S_LATENCY = devcap_pkg::L0S_LAT_RESET,
    parameter logic [2:0] L1_LATENCY  = devcap_pkg::L1_LAT_RESET
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // straps, asynchronous to aclk
    input  wire logic                     hotplug_strap,
    input  wire logic                     forward_bridge,
    // slot power limit message from the link layer, same clock
    input  wire logic                     spl_msg_valid,
    input  wire devcap_pkg::slot_power_t  spl_msg,
    // axi4-lite slave
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);

    // ------------------------------------------------------------
    // strap synchronisers
    // ------------------------------------------------------------
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic       hotplug_fwd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_meta <= 2'h0;
            strap_sync <= 2'h0;
        end else begin
            strap_meta <= {hotplug_strap, forward_bridge};
            strap_sync <= strap_meta;
        end
    end

    // presence bits only when hot-plug is strapped in forward-bridge mode
    assign hotplug_fwd = strap_sync[1] & strap_sync[0];

    logic hotplug_bits;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hotplug_bits <= 1'b0;
        end else begin
            hotplug_bits <= hotplug_fwd; // see RULE6 RULE7 RULE8
        end
    end

    // ------------------------------------------------------------
    // captured slot power limit
    // ------------------------------------------------------------
    logic [7:0] spl_value;
    logic [1:0] spl_scale;

    cap_field_reg #(
        .WIDTH       (8),
        .RESET_VALUE (devcap_pkg::SPL_VALUE_RESET)
    ) u_spl_value (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .load       (spl_msg_valid),
        .load_value (spl_msg.value),
        .value      (spl_value)
    ); // see RULE9

    cap_field_reg #(
        .WIDTH       (2),
        .RESET_VALUE (devcap_pkg::SPL_SCALE_RESET)
    ) u_spl_scale (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .load       (spl_msg_valid),
        .load_value (spl_msg.scale),
        .value      (spl_scale)
    ); // see RULE10

    // ------------------------------------------------------------
    // register image
    // ------------------------------------------------------------
    logic [31:0] cap_word;

    always_comb begin
        cap_word = 32'h0000_0000; // see RULE11
        cap_word[devcap_pkg::PAYLOAD_LSB +: 3]   = MAX_PAYLOAD; // see RULE1
        cap_word[devcap_pkg::PHANTOM_LSB +: 2]   = devcap_pkg::PHANTOM_RESET; // see RULE2
        cap_word[devcap_pkg::EXT_TAG_BIT]        = devcap_pkg::EXT_TAG_RESET; // see RULE3
        cap_word[devcap_pkg::L0S_LAT_LSB +: 3]   = L0S_LATENCY; // see RULE4
        cap_word[devcap_pkg::L1_LAT_LSB +: 3]    = L1_LATENCY; // see RULE5
        cap_word[devcap_pkg::ATTN_BTN_BIT]       = hotplug_bits; // see RULE6
        cap_word[devcap_pkg::ATTN_IND_BIT]       = hotplug_bits; // see RULE7
        cap_word[devcap_pkg::PWR_IND_BIT]        = hotplug_bits; // see RULE8
        cap_word[devcap_pkg::SPL_VALUE_LSB +: 8] = spl_value; // see RULE9
        cap_word[devcap_pkg::SPL_SCALE_LSB +: 2] = spl_scale; // see RULE10
    end

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    // address and data are taken independently; the response goes out once
    // both are in. the register is read only, so data is discarded.
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    wire        aw_take  = s_axi_awvalid & s_axi_awready;
    wire        w_take   = s_axi_wvalid & s_axi_wready;
    wire        aw_have  = aw_held | aw_take;
    wire        w_have   = w_held | w_take;
    wire [7:0]  wr_addr  = aw_take ? s_axi_awaddr : aw_addr;
    wire        wr_fire  = aw_have & w_have & ~s_axi_bvalid;
    wire        wr_hit   = wr_addr[7:2] == devcap_pkg::DEVICE_CAPABILITIES_OFFSET[7:2];
    wire [1:0]  wr_resp  = wr_hit ? devcap_pkg::RESP_OKAY : devcap_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= devcap_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            aw_held       <= aw_have & ~wr_fire;
            w_held        <= w_have & ~wr_fire;
            s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
            s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_resp; // see RULE11
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    wire        ar_take = s_axi_arvalid & s_axi_arready;
    wire        rd_hit  = s_axi_araddr[7:2] == devcap_pkg::DEVICE_CAPABILITIES_OFFSET[7:2];
    wire [31:0] rd_data = rd_hit ? cap_word : 32'h0000_0000;
    wire [1:0]  rd_resp = rd_hit ? devcap_pkg::RESP_OKAY : devcap_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= devcap_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_resp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

//--- dv/devcap_props.sv
`timescale 1ns/100ps
`default_nettype none
module devcap_props (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    hotplug_strap,
    input wire logic                    forward_bridge,
    input wire logic                    spl_msg_valid,
    input wire devcap_pkg::slot_power_t spl_msg,
    input wire logic [7:0]              s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [9:0] last_spl;
    logic [9:0] spl_at_ar;
    logic [1:0] strap_prev;
    logic [3:0] strap_age;
    // read data is latched at the address edge, so compare with the image seen there
    always_ff @(posedge aclk) begin
        strap_prev <= {hotplug_strap, forward_bridge};
        if (!aresetn) begin
            last_spl <= '0;
            spl_at_ar <= '0;
        end else begin
            if (spl_msg_valid) last_spl <= spl_msg;
            if (s_axi_arvalid && s_axi_arready) spl_at_ar <= last_spl;
        end
        // straps pass a synchroniser: judge them only once they have settled
        if (!aresetn || strap_prev != {hotplug_strap, forward_bridge}) strap_age <= '0;
        else if (strap_age != 4'hF) strap_age <= strap_age + 4'h1;
    end
    sequence s_ok;
        s_axi_rvalid && s_axi_rresp == devcap_pkg::RESP_OKAY;
    endsequence
    property p_payload; s_ok |-> s_axi_rdata[2:0] == devcap_pkg::PAYLOAD_RESET; endproperty
    property p_fixed; s_ok |-> s_axi_rdata[5:3] == 3'h4; endproperty
    property p_latency; s_ok |-> s_axi_rdata[11:6] == 6'h00; endproperty
    property p_hotplug;
        s_ok ##0 strap_age == 4'hF |-> s_axi_rdata[14:12] == {3{hotplug_strap & forward_bridge}};
    endproperty
    property p_spl; s_ok |-> s_axi_rdata[27:18] == spl_at_ar; endproperty
    property p_rsvd; s_ok |-> s_axi_rdata[17:15] == 3'h0 && s_axi_rdata[31:28] == 4'h0; endproperty
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] != 6'h2D
            |=> s_axi_rvalid && s_axi_rresp == devcap_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_payload: assert property (p_payload) else $error("payload code wrong");
    a_fixed: assert property (p_fixed) else $error("tag or phantom field wrong");
    a_latency: assert property (p_latency) else $error("latency fields wrong");
    a_hotplug: assert property (p_hotplug) else $error("hot-plug bits wrong");
    a_spl: assert property (p_spl) else $error("slot power capture wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
endmodule
bind device_capabilities_regs devcap_props u_props (.aclk, .aresetn, .hotplug_strap,
    .forward_bridge, .spl_msg_valid, .spl_msg, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- dv/slot_power_source.sv
`timescale 1ns/100ps
`default_nettype none
module slot_power_source (
    input wire logic                    aclk,
    input wire logic                    send_req,
    input wire devcap_pkg::slot_power_t send_msg,
    output logic                        spl_msg_valid,
    output devcap_pkg::slot_power_t     spl_msg
);
    // outside a message the payload shows the inverse, never a stale copy
    always_ff @(posedge aclk) begin
        spl_msg_valid <= send_req;
        spl_msg <= send_req ? send_msg : ~send_msg;
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    logic        aclk, aresetn, hotplug_strap, forward_bridge, send_req, spl_msg_valid;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, s_axi_bready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [31:0] s_axi_rdata, rd_data;
    devcap_pkg::slot_power_t spl_msg, send_msg;
    int          n_fail = 0, n_tests = 0;
    slot_power_source partner (.aclk, .send_req, .send_msg, .spl_msg_valid, .spl_msg);
    device_capabilities_regs dut (.aclk, .aresetn, .hotplug_strap, .forward_bridge,
        .spl_msg_valid, .spl_msg, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata(32'hFFFFFFFF), .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask
    task automatic wr(input logic [7:0] a);
        logic aw_done = 1'b0, w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) aw_done = 1'b1;
            if (s_axi_wready === 1'b1) w_done = 1'b1;
            if (aw_done) s_axi_awvalid <= 1'b0;
            if (w_done) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        wr_resp = s_axi_bresp;
    endtask
    task automatic t_reset;
        rd(8'hB4);
        `CHK(rd_data[2:0], 3'h1)
        `CHK(rd_data[4:3], 2'h0)
        `CHK(rd_data[5], 1'b1)
        `CHK(rd_data[8:6], 3'h0)
        `CHK(rd_data[11:9], 3'h0)
        `CHK(rd_data[14:12], 3'h0)
        `CHK(rd_data[27:18], 10'h000)
        `CHK({rd_data[31:28], rd_data[17:15]}, 7'h00)
    endtask
    task automatic t_hotplug;
        for (int i = 0; i < 4; i++) begin
            hotplug_strap <= i[0];
            forward_bridge <= i[1];
            repeat (20) @(posedge aclk);
            rd(8'hB4);
            `CHK(rd_data[14:12], {3{i == 3}})
        end
    endtask
    task automatic t_spl;
        send_req <= 1'b1;
        send_msg <= 10'h2A5;
        @(posedge aclk);
        send_msg <= 10'h13C;
        @(posedge aclk);
        send_req <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(8'hB4);
        `CHK(rd_data[27:18], 10'h13C)
        send_req <= 1'b1;
        send_msg <= 10'h3FF;
        @(posedge aclk);
        send_req <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(8'hB4);
        `CHK(rd_data[27:18], 10'h3FF)
    endtask
    task automatic t_writes;
        wr(8'hB4);
        `CHK(wr_resp, devcap_pkg::RESP_OKAY)
        wr(8'h10);
        `CHK(wr_resp, devcap_pkg::RESP_SLVERR)
        rd(8'hB4);
        `CHK(rd_data, {4'h0, 10'h3FF, 3'h0, 3'h7, 6'h00, 3'h4, 3'h1})
        rd(8'hB8);
        `CHK({rd_resp, rd_data}, {devcap_pkg::RESP_SLVERR, 32'h0})
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        {aresetn, hotplug_strap, forward_bridge, send_req, send_msg} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
        // responses are always accepted at once
        {s_axi_bready, s_axi_rready} = 2'h3;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_hotplug();
        t_spl();
        t_writes();
        report_and_stop();
    end
endmodule
`default_nettype wire
